// *** hdl/power_sequence_fault_control.sv ***
/*
 * Control logic of a four-output power manager: startup, shutdown, chained
 * sequencing, fault handling, sticky fault flags, power-good and alert output.
 * Assumes register writes arrive as decoded one-cycle strobes from a serial
 * front end, and analog detectors are clocked-domain level inputs.
 */
`timescale 1ns/1ps
module power_sequence_fault_control #(
    parameter bit SEQ_CAPABLE = 1'b1
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     clk_en,
    input  wire logic                     master_on_pin,
    input  wire logic                     main_supply_input_ok,
    input  wire logic                     thermal_trip_det,
    input  wire logic                     low_supply_det,
    input  wire logic [3:0]               above_90_det,
    input  wire logic [3:0]               below_85_det,
    input  wire logic                     ctl_write,
    input  wire pwr_seq_pkg::ctl_fields_s ctl_wdata,
    input  wire logic [3:0]               vcode_write,
    input  wire logic [5:0]               vcode_wdata,
    input  wire logic                     flag_clear_write,
    input  wire logic [1:0]               flag_clear_mask,
    output pwr_seq_pkg::ctl_fields_s      ctl_fields,
    output pwr_seq_pkg::vcodes_s          vcodes,
    output logic [3:0]                    supply_on,
    output logic                          bias_on,
    output logic                          thermal_trip,
    output logic                          low_supply_lockout,
    output logic [3:0]                    power_good,
    output logic                          fault_alert_n
);
    import pwr_seq_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers and edge detection
    logic [3:0] sync1_reg;
    logic [3:0] sync1_next;
    logic [3:0] sync2_reg;
    logic [3:0] sync2_next;
    logic       pin_prev_reg;
    logic       pin_prev_next;
    logic       init_reg;
    logic       init_next;
    logic       pin_s, therm_s, low_s, por_s;
    logic       pin_rise, pin_fall, fault_now;

    always_comb begin
        sync1_next    = {main_supply_input_ok, low_supply_det, thermal_trip_det, master_on_pin};
        sync2_next    = sync1_reg;
        // Held low through any power-on, so a pin still high afterwards is a new rise
        pin_prev_next = por_s ? 1'b0 : sync2_reg[0];
        init_next     = 1'b0;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_reg    <= 4'h0;
            sync2_reg    <= 4'h0;
            pin_prev_reg <= 1'b0;
            init_reg     <= 1'b1;
        end else if (clk_en) begin
            sync1_reg    <= sync1_next;
            sync2_reg    <= sync2_next;
            pin_prev_reg <= pin_prev_next;
            init_reg     <= init_next;
        end
    end

    assign pin_s     = sync2_reg[0];
    assign therm_s   = sync2_reg[1];
    assign low_s     = sync2_reg[2];
    assign por_s     = init_reg | ~sync2_reg[3];
    // Previous sample reset low, so a pin already high at release reads as a rise
    assign pin_rise  = pin_s & ~pin_prev_reg;
    assign pin_fall  = ~pin_s & pin_prev_reg;
    assign fault_now = therm_s | low_s;

    ////////////////////////////////////////////////////////////////////////////
    // Control state, register fields and fault flags
    ctl_state_e  state_reg;
    ctl_state_e  state_next;
    ctl_fields_s fld_reg;
    ctl_fields_s fld_next;
    vcodes_s     vc_reg;
    vcodes_s     vc_next;
    logic        therm_flag_reg;
    logic        therm_flag_next;
    logic        low_flag_reg;
    logic        low_flag_next;
    logic [3:0]  def_enables;

    // Default set depends on variant
    assign def_enables = SEQ_CAPABLE ? ENABLES_SEQ_DEF : ENABLES_NOSEQ_DEF;

    function automatic ctl_fields_s startup_fields(input ctl_fields_s f, input logic [3:0] en);
        ctl_fields_s r;
        r             = f;
        r.enables     = en;
        r.seq_disable = 1'b0;
        r.restart     = RESTART_RST;
        return r;
    endfunction

    // A control write with every enable clear is a shutdown request
    function automatic logic all_off_write(input logic wr, input ctl_fields_s d);
        return wr && (d.enables == 4'h0);
    endfunction

    always_comb begin
        state_next = state_reg;
        fld_next   = fld_reg;
        vc_next    = vc_reg;
        if (ctl_write) begin
            fld_next = ctl_wdata;
            if (!SEQ_CAPABLE)
                fld_next.seq_disable = 1'b0;
        end
        for (int i = 0; i < SUPPLY_COUNT; i++) begin
            if (vcode_write[i])
                vc_next[i*VCODE_W +: VCODE_W] = vcode_wdata;
        end
        case (state_reg)
            ST_OFF: begin
                if (fault_now) begin
                    state_next = ST_FAULT;
                end else if (pin_rise) begin
                    state_next = ST_START;
                end else if (ctl_write && !all_off_write(ctl_write, ctl_wdata)) begin
                    state_next = ST_ON;
                end
            end
            ST_START: begin
                // One cycle to reload defaults, then run the chain
                fld_next   = startup_fields(fld_reg, def_enables);
                vc_next    = VCODES_RST;
                state_next = ST_ON;
            end
            ST_ON: begin
                if (fault_now) begin
                    state_next = ST_FAULT;
                end else if (pin_fall) begin
                    fld_next.enables = 4'h0;
                    state_next       = ST_OFF;
                end else if (pin_rise) begin
                    state_next = ST_START;
                end else if (all_off_write(ctl_write, ctl_wdata)) begin
                    state_next = ST_OFF;
                end
            end
            ST_FAULT: begin
                // Outputs held off, bias kept, enables, seq_disable and voltage codes held at defaults
                fld_next.enables     = ENABLES_RST;
                fld_next.seq_disable = 1'b0;
                vc_next              = VCODES_RST;
                if (pin_fall || all_off_write(ctl_write, ctl_wdata)) begin
                    state_next = ST_OFF;
                end else if (!fault_now) begin
                    state_next = fld_reg.restart ? ST_START : ST_OFF;
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst || (clk_en && por_s)) begin
            state_reg      <= ST_OFF;
            fld_reg        <= '{ENABLES_RST, SEQ_DIS_RST, RESTART_RST, INT_ALLOW_RST};
            vc_reg         <= VCODES_RST;
        end else if (clk_en) begin
            state_reg      <= state_next;
            fld_reg        <= fld_next;
            vc_reg         <= vc_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky fault flags, kept through shutdown and cleared by power-on or a write-one clear
    always_comb begin
        therm_flag_next = therm_flag_reg;
        low_flag_next   = low_flag_reg;
        // Write-one clear first, so a live detector below wins the same cycle
        if (flag_clear_write) begin
            therm_flag_next = therm_flag_reg & ~flag_clear_mask[0];
            low_flag_next   = low_flag_reg & ~flag_clear_mask[1];
        end
        if (therm_s) begin
            therm_flag_next = 1'b1;
        end
        if (low_s) begin
            low_flag_next = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || (clk_en && por_s)) begin
            therm_flag_reg <= 1'b0;
            low_flag_reg   <= 1'b0;
        end else if (clk_en) begin
            therm_flag_reg <= therm_flag_next;
            low_flag_reg   <= low_flag_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power-good hysteresis and chained supply enables
    logic [3:0] pg_reg;
    logic [3:0] pg_next;
    logic [3:0] on_reg;
    logic [3:0] on_next;
    logic [3:0] upstream_ok;

    function automatic logic [1:0] chain_pos(input int idx);
        return SEQ_ORDER_DEF[idx*2 +: 2];
    endfunction

    always_comb begin
        pg_next = pg_reg;
        for (int i = 0; i < SUPPLY_COUNT; i++) begin
            if (above_90_det[i])
                pg_next[i] = 1'b1;
            else if (below_85_det[i])
                pg_next[i] = 1'b0;
        end
    end

    // Outputs held off outside ON, so fault or shutdown drops them all at once
    always_comb begin
        // Every enabled earlier supply in the chain must be good; disabled ones are skipped
        for (int i = 0; i < SUPPLY_COUNT; i++) begin
            upstream_ok[i] = 1'b1;
            for (int j = 0; j < SUPPLY_COUNT; j++) begin
                if (chain_pos(j) < chain_pos(i) && fld_reg.enables[j] && !pg_reg[j])
                    upstream_ok[i] = 1'b0;
            end
        end
        on_next = 4'h0;
        if (state_reg == ST_ON) begin
            if (SEQ_CAPABLE && !fld_reg.seq_disable)
                on_next = fld_reg.enables & upstream_ok;
            else
                on_next = fld_reg.enables;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pg_reg <= 4'h0;
        end else if (clk_en) begin
            pg_reg <= pg_next;
        end
    end

    // Registered, so a chained supply starts one cycle after its upstream is good
    always_ff @(posedge clk) begin
        if (rst) begin
            on_reg <= 4'h0;
        end else if (clk_en) begin
            on_reg <= on_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign ctl_fields         = fld_reg;
    assign vcodes             = vc_reg;
    assign supply_on          = on_reg;
    assign bias_on            = (state_reg != ST_OFF);
    assign thermal_trip       = therm_flag_reg;
    assign low_supply_lockout = low_flag_reg;
    assign power_good         = pg_reg;
    // Open-drain style alert, low while flagged and allowed
    assign fault_alert_n      = ~(fld_reg.int_allow & (therm_flag_reg | low_flag_reg));
endmodule

// *** hdl/pwr_seq_pkg.sv ***
/*
 * Shared constants, types and field layout for the power sequence and fault control block.
 * Assumes a single 40 MHz clock domain and synchronous active-high reset.
 */
package pwr_seq_pkg;
    localparam int          SUPPLY_COUNT     = 4;
    localparam int          VCODE_W          = 6;
    // Supply order inside every supply vector
    localparam int          BUCK_POS         = 0;
    localparam int          LIN1_POS         = 1;
    localparam int          LIN2_POS         = 2;
    localparam int          LIN3_POS         = 3;
    // Power-on defaults of the control fields
    localparam logic        RESTART_RST      = 1'h1;
    localparam logic        SEQ_DIS_RST      = 1'h0;
    localparam logic        INT_ALLOW_RST    = 1'h0;
    localparam logic [3:0]  ENABLES_RST      = 4'h0;
    // Enable sets loaded by a default startup
    localparam logic [3:0]  ENABLES_SEQ_DEF  = 4'hf;
    localparam logic [3:0]  ENABLES_NOSEQ_DEF = 4'h1;
    // Voltage code defaults (plain values, per supply)
    localparam logic [5:0]  VCODE_BUCK_RST   = 6'h10;
    localparam logic [5:0]  VCODE_LIN1_RST   = 6'h14;
    localparam logic [5:0]  VCODE_LIN2_RST   = 6'h14;
    localparam logic [5:0]  VCODE_LIN3_RST   = 6'h14;
    // Chain position of each supply (0 is first); buck, linear1, linear2, linear3
    localparam logic [7:0]  SEQ_ORDER_DEF    = 8'he1;

    typedef enum logic [3:0] {
        ST_OFF     = 4'b0001,
        ST_ON      = 4'b0010,
        ST_FAULT   = 4'b0100,
        ST_START   = 4'b1000
    } ctl_state_e;

    typedef struct packed {
        logic [3:0] enables;
        logic       seq_disable;
        logic       restart;
        logic       int_allow;
    } ctl_fields_s;

    typedef struct packed {
        logic [5:0] code3;
        logic [5:0] code2;
        logic [5:0] code1;
        logic [5:0] code0;
    } vcodes_s;

    localparam vcodes_s     VCODES_RST = '{VCODE_LIN3_RST, VCODE_LIN2_RST,
                                           VCODE_LIN1_RST, VCODE_BUCK_RST};
endpackage

// *** testbench/supply_model.sv ***
/*
 * Far-side model of the four regulators and their good comparators.
 * Assumes one clock; an output counts as good two cycles after its on command.
 */
`timescale 1ns/1ps
module supply_model (
    input  wire logic       clk,
    input  wire logic [3:0] supply_on,
    output logic      [3:0] above_90_det,
    output logic      [3:0] below_85_det
);
    logic [3:0] ramp1_reg;
    logic [3:0] ramp2_reg;
    // Slow ramp so a downstream supply really has to wait
    always_ff @(posedge clk) begin
        ramp1_reg <= supply_on;
        ramp2_reg <= ramp1_reg & supply_on;
    end
    assign above_90_det = ramp2_reg & supply_on;
    assign below_85_det = ~supply_on;
endmodule

// *** testbench/pwr_seq_sva.sv ***
/*
 * Port checker for the power sequence and fault control block.
 * Assumes clk_en is held high, so every clock edge is a working edge.
 */
`timescale 1ns/1ps
module pwr_seq_sva
    import pwr_seq_pkg::*;
(
    input wire logic                     clk,
    input wire logic                     rst,
    input wire logic                     main_supply_input_ok,
    input wire logic                     master_on_pin,
    input wire logic [3:0]               above_90_det,
    input wire logic [3:0]               below_85_det,
    input wire logic [3:0]               vcode_write,
    input wire logic [5:0]               vcode_wdata,
    input wire logic                     flag_clear_write,
    input wire logic [1:0]               flag_clear_mask,
    input wire pwr_seq_pkg::ctl_fields_s ctl_fields,
    input wire pwr_seq_pkg::vcodes_s     vcodes,
    input wire logic [3:0]               supply_on,
    input wire logic                     bias_on,
    input wire logic                     thermal_trip,
    input wire logic                     low_supply_lockout,
    input wire logic [3:0]               power_good,
    input wire logic                     fault_alert_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [3:0] ok_age_reg;
    // Main supply loss acts as a reset, so flag checks wait for it to settle
    always_ff @(posedge clk) begin
        if (rst || !main_supply_input_ok) begin
            ok_age_reg <= 4'h0;
        end else if (ok_age_reg != 4'hf) begin
            ok_age_reg <= ok_age_reg + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    a_reset_defaults: assert property (disable iff (1'b0) rst |=>
        ctl_fields == 7'h02
        && vcodes == VCODES_RST && supply_on == 4'h0 && fault_alert_n)
        else $error("reset defaults wrong");
    a_alert_level: assert property (fault_alert_n ==
        !(ctl_fields.int_allow && (thermal_trip || low_supply_lockout)))
        else $error("alert level wrong");
    a_fault_off: assert property ($rose(thermal_trip) || $rose(low_supply_lockout)
        |-> ##[0:2] (supply_on == 4'h0 && bias_on)) else $error("fault left outputs on");
    a_flag_sticky: assert property (thermal_trip && ok_age_reg == 4'hf
        && !(flag_clear_write && flag_clear_mask[0]) |=> thermal_trip)
        else $error("thermal flag lost");
    a_pin_fall_off: assert property ($fell(master_on_pin) && supply_on == 4'hf
        |-> ##[1:6] (supply_on == 4'h0 && ctl_fields.enables == 4'h0))
        else $error("pin fall did not shut down");
    a_good_set: assert property (above_90_det != 4'h0 && ok_age_reg == 4'hf
        |=> (power_good & $past(above_90_det)) == $past(above_90_det))
        else $error("power good not set");
    a_good_clear: assert property ((below_85_det & ~above_90_det) != 4'h0
        |=> (power_good & $past(below_85_det) & ~$past(above_90_det)) == 4'h0)
        else $error("power good not cleared");
    a_vcode_apply: assert property (vcode_write[0] && supply_on[0] && !thermal_trip
        && !low_supply_lockout |=> vcodes.code0 == $past(vcode_wdata))
        else $error("voltage code not applied");
    // Chain starts with linear1, then buck: buck must wait for linear1 good
    a_chain_good: assert property ($rose(supply_on[0]) && ctl_fields.enables[1]
        && !ctl_fields.seq_disable |-> $past(power_good[1]))
        else $error("chained supply started early");
endmodule
bind power_sequence_fault_control pwr_seq_sva i_pwr_seq_sva (.clk, .rst, .main_supply_input_ok,
    .master_on_pin, .above_90_det, .below_85_det, .vcode_write, .vcode_wdata, .flag_clear_write,
    .flag_clear_mask, .ctl_fields, .vcodes, .supply_on, .bias_on, .thermal_trip,
    .low_supply_lockout, .power_good, .fault_alert_n);

// *** testbench/tb_top.sv ***
/*
 * Directed bench for the power sequence and fault control block.
 * Assumes the regulator model supplies the good comparators.
 */
`timescale 1ns/1ps
module tb_top;
    import pwr_seq_pkg::*;
    logic        clk = 0, rst = 1, pin = 0, ok = 1, tdet = 0, ldet = 0, cw = 0, fw = 0;
    logic [3:0]  a90, b85, son, pg, vw = 4'h0;
    logic [5:0]  vd = 6'h0;
    logic [1:0]  fm = 2'h0;
    logic        bias, tt, ll, al;
    ctl_fields_s cd = '0, cf;
    vcodes_s     vc;
    int          errors = 0, compares = 0;
    always #12.5 clk = ~clk;
    power_sequence_fault_control i_power_sequence_fault_control (.clk(clk), .rst(rst),
        .clk_en(1'b1), .master_on_pin(pin), .main_supply_input_ok(ok), .thermal_trip_det(tdet),
        .low_supply_det(ldet), .above_90_det(a90), .below_85_det(b85), .ctl_write(cw),
        .ctl_wdata(cd), .vcode_write(vw), .vcode_wdata(vd), .flag_clear_write(fw),
        .flag_clear_mask(fm), .ctl_fields(cf), .vcodes(vc), .supply_on(son), .bias_on(bias),
        .thermal_trip(tt), .low_supply_lockout(ll), .power_good(pg), .fault_alert_n(al));
    supply_model i_supply_model (.clk(clk), .supply_on(son), .above_90_det(a90),
        .below_85_det(b85));
    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Pin only moves once a serial write has ended
    task automatic put_ctl(input logic [6:0] d);
        cd = d;
        cw = 1;
        tick(1);
        cw = 0;
    endtask
    task automatic put_code(input int i, input logic [5:0] v);
        vw = 4'h1 << i;
        vd = v;
        tick(1);
        vw = 4'h0;
    endtask
    task automatic clr(input logic [1:0] m);
        fm = m;
        fw = 1;
        tick(1);
        fw = 0;
    endtask
    task automatic wait_on(input logic [3:0] e);
        int k;
        for (k = 0; k < 60 && son !== e; k++) tick(1);
        chk(son, e);
    endtask
    task automatic final_report;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #(25 * 4000);
        errors++;
        final_report();
    end
    initial begin
        tick(4);
        rst = 0;
        tick(8);
        chk({cf, son, al}, {7'h02, 4'h0, 1'b1});
        chk(vc, VCODES_RST);
        put_code(1, 6'h2a);
        chk(vc.code1, 6'h2a);
        put_ctl(7'h06);
        pin = 1;
        wait_on(4'hf);
        chk(cf, 7'h7a);
        chk(vc, VCODES_RST);
        tick(4);
        chk(pg, 4'hf);
        put_ctl(7'h7f);
        put_code(0, 6'h01);
        chk(vc.code0, 6'h01);
        tdet = 1;
        tick(6);
        chk({tt, al, bias, son}, 7'h50);
        chk(vc, VCODES_RST);
        chk({cf.seq_disable, cf.restart}, 2'h1);
        clr(2'h1);
        tick(4);
        chk(tt, 1'b1);
        tdet = 0;
        wait_on(4'hf);
        chk({tt, al}, 2'h2);
        clr(2'h1);
        tick(1);
        chk({tt, al}, 2'h1);
        put_ctl(7'h7d);
        ldet = 1;
        tick(6);
        chk(ll, 1'b1);
        ldet = 0;
        tick(10);
        chk({son, bias}, 5'h0);
        put_ctl(7'h20);
        wait_on(4'h4);
        put_ctl(7'h00);
        wait_on(4'h0);
        chk(bias, 1'b0);
        pin = 0;
        tick(8);
        chk({son, cf.enables}, 8'h0);
        pin = 1;
        wait_on(4'hf);
        ldet = 1;
        tick(6);
        chk(ll, 1'b1);
        ok = 0;
        ldet = 0;
        tick(3);
        ok = 1;
        tick(10);
        chk(ll, 1'b0);
        wait_on(4'hf);
        pin = 0;
        wait_on(4'h0);
        chk({cf.enables, bias}, 5'h0);
        tick(2);
        chk(pg, 4'h0);
        final_report();
    end
endmodule
